// ---- logic/serial_sram_ctrl.sv ----
`timescale 1ns/1ns

// ****************************************************************
// write data buffer
// ****************************************************************
module sram_fifo #(
  parameter int WIDTH = 25,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] buf_q [DEPTH];
  logic [AW:0]      wp;
  logic [AW:0]      rp;
  logic [AW:0]      next_wp;
  logic [AW:0]      next_rp;
  logic             push;
  logic             pop;

  // full when pointers differ only in the wrap bit
  assign in_ready  = !((wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]));
  assign out_valid = (wp != rp);
  assign out_data  = buf_q[rp[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // pointer advance
  always_comb begin
    next_wp = wp + (AW+1)'(push);
    next_rp = rp + (AW+1)'(pop);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wp <= '0;
      rp <= '0;
    end else begin
      wp <= next_wp;
      rp <= next_rp;
    end
    if (push) begin
      buf_q[wp[AW-1:0]] <= in_data;
    end
  end
endmodule

// ****************************************************************
// serial sram command interpreter
// ****************************************************************
// How it works
// - read-mode command streams out the mode register, allowed any time
// - mode bits 7:6 pick byte, page or sequential; sequential after reset
// - write-mode command loads the next byte into the mode register
// - enter-dual command switches the link to two bits per clock
// - dual mode moves two bits per clock, most significant first
// - enter-quad command switches the link to four bits per clock
// - quad mode moves one nibble per clock, upper nibble first
// - exit command in dual or quad returns the link to one bit
// - dual read waits four clocks, one dummy byte, after the address
// - dual write takes data right after the address, no wait
// - read and write take a 24-bit address, top seven bits ignored
// - page mode wraps in 32 bytes; sequential rolls over at top
// - pause by hold pin is unavailable in quad mode
module serial_sram_ctrl
  import sram_pkg::*;
#(
  parameter int AW    = sram_pkg::ADDR_W,
  parameter int DEPTH = sram_pkg::FIFO_DEPTH
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       cs_n,
  input  wire logic       sck,
  input  wire logic [3:0] io_in,
  output logic [3:0]      io_out,
  output logic [3:0]      io_oe_n,
  output logic [7:0]      operating_mode_register,
  output logic            dual_width_mode,
  output logic            quad_width_mode
);
  import sram_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE, ST_CMD, ST_ADDR, ST_DUMMY, ST_RDATA,
    ST_WDATA, ST_MRD, ST_MWR, ST_IGNORE
  } state_e;

  // bits moved per serial clock
  function automatic logic [4:0] bpc(input width_e w);
    case (w)
      w_dual:  return 5'h02;
      w_quad:  return 5'h04;
      default: return 5'h01;
    endcase
  endfunction

  // shift incoming lines into the low end, msb first
  function automatic logic [23:0] shift_in(input logic [23:0] s,
                                           input logic [3:0] d,
                                           input width_e w);
    case (w)
      w_dual:  return {s[21:0], d[1:0]};
      w_quad:  return {s[19:0], d};
      default: return {s[22:0], d[0]};
    endcase
  endfunction

  // top bits of a byte onto the lines; single mode uses line one
  function automatic logic [3:0] out_bits(input logic [7:0] b,
                                          input width_e w);
    case (w)
      w_dual:  return {2'b00, b[7:6]};
      w_quad:  return b[7:4];
      default: return {2'b00, b[7], 1'b0};
    endcase
  endfunction

  // lines driven during a read, active low
  function automatic logic [3:0] oe_mask(input width_e w);
    case (w)
      w_dual:  return 4'hc;
      w_quad:  return 4'h0;
      default: return 4'hd;
    endcase
  endfunction

  // address advance per addressing mode
  function automatic logic [AW-1:0] next_addr(input logic [AW-1:0] a,
                                              input logic [1:0] m);
    case (m)
      MODE_PAGE: return {a[AW-1:PAGE_BITS], a[PAGE_BITS-1:0] + 1'b1};
      MODE_SEQ:  return a + 1'b1;
      default:   return a;
    endcase
  endfunction

  // ****************************************************************
  // pin synchronisers and edge detection
  // ****************************************************************
  logic [5:0] sync1;
  logic [5:0] sync2;
  logic       sck_d;
  logic       cs_act;
  logic       rise;
  logic       fall;
  logic       paused;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1 <= 6'h2f; // idle levels: deselected, clock low
      sync2 <= 6'h2f;
      sck_d <= 1'b0; // no false clock edge after reset
    end else begin
      sync1 <= {cs_n, sck, io_in};
      sync2 <= sync1;
      sck_d <= sync2[4];
    end
  end

  logic [3:0] io_s;
  assign io_s   = sync2[3:0];
  assign cs_act = !sync2[5];
  assign rise   = sync2[4] && !sck_d;
  assign fall   = !sync2[4] && sck_d;

  // ****************************************************************
  // command state
  // ****************************************************************
  state_e        state;
  state_e        next_state;
  width_e        width;
  width_e        next_width;
  logic [7:0]    next_mode;
  logic [23:0]   sh;
  logic [23:0]   next_sh;
  logic [4:0]    cnt;
  logic [4:0]    next_cnt;
  logic [AW-1:0] addr;
  logic [AW-1:0] next_addr_q;
  logic          is_read;
  logic          next_is_read;
  logic [7:0]    out_sh;
  logic [7:0]    next_out_sh;
  logic [3:0]    ocnt;
  logic [3:0]    next_ocnt;
  logic          driving;
  logic          next_driving;
  logic          sent;
  logic          next_sent;
  logic [3:0]    next_io_out;
  logic [3:0]    next_io_oe_n;
  logic          byte_done;
  logic          push;
  logic          in_ready;
  logic [7:0]    ram [2**AW];
  logic          wb_valid;
  logic [AW+7:0] wb_data;
  logic          wb_ready;

  // hold pin is line three except in quad mode
  assign paused = (width != w_quad) && !io_s[3];

  always_comb begin
    logic [4:0] n;
    logic [7:0] ob;
    n            = cnt + bpc(width);
    ob           = out_sh;
    next_state   = state;
    next_width   = width;
    next_mode    = operating_mode_register;
    next_sh      = sh;
    next_cnt     = cnt;
    next_addr_q  = addr;
    next_is_read = is_read;
    next_out_sh  = out_sh;
    next_ocnt    = ocnt;
    next_driving = driving;
    next_sent    = sent;
    next_io_out  = io_out;
    byte_done    = 1'b0;
    push         = 1'b0;
    if (!cs_act) begin
      // deselect ends any command
      next_state   = ST_IDLE;
      next_driving = 1'b0;
    end else if (state == ST_IDLE) begin
      next_state = ST_CMD;
      next_cnt   = '0;
      next_sent  = 1'b0;
      next_ocnt  = '0;
    end else if (!paused && rise) begin
      // every phase takes bits at the active width
      next_sh  = shift_in(sh, io_s, width);
      next_cnt = n;
      case (state)
        ST_CMD: begin
          if (n == CMD_BITS) begin
            next_cnt   = '0;
            next_state = ST_IGNORE;
            case (next_sh[7:0])
              CMD_READ: begin
                next_state   = ST_ADDR;
                next_is_read = 1'b1;
              end
              CMD_WRITE: begin
                next_state   = ST_ADDR;
                next_is_read = 1'b0;
              end
              read_mode_cmd:  next_state = ST_MRD;
              write_mode_cmd: next_state = ST_MWR;
              enter_dual_cmd: next_width = w_dual;
              enter_quad_cmd: next_width = w_quad;
              exit_wide_cmd:  next_width = w_single;
              default:        next_state = ST_IGNORE;
            endcase
          end
        end
        ST_ADDR: begin
          if (n == ADDR_BITS) begin
            // upper address bits fall off the narrow pointer
            next_addr_q = next_sh[AW-1:0];
            next_cnt    = '0;
            if (!is_read) begin
              next_state = ST_WDATA;
            end else if (width == w_dual) begin
              next_state = ST_DUMMY;
            end else begin
              next_state = ST_RDATA;
            end
          end
        end
        ST_DUMMY: begin
          if (n == DUMMY_BITS) begin
            next_cnt   = '0;
            next_state = ST_RDATA;
          end
        end
        ST_WDATA: begin
          if (n == CMD_BITS && in_ready) begin
            byte_done   = 1'b1;
            push        = 1'b1;
            next_cnt    = '0;
            next_addr_q = next_addr(addr,
              operating_mode_register[MODE_HI:MODE_LO]);
            if (operating_mode_register[MODE_HI:MODE_LO] == MODE_BYTE) begin
              next_state = ST_IGNORE;
            end
          end
        end
        ST_MWR: begin
          if (n == CMD_BITS) begin
            byte_done  = 1'b1;
            next_mode  = next_sh[7:0];
            next_state = ST_IGNORE;
          end
        end
        default: next_cnt = cnt;
      endcase
    end else if (!paused && fall &&
                 (state == ST_RDATA || state == ST_MRD)) begin
      if (ocnt == '0) begin
        ob = (state == ST_MRD) ? operating_mode_register : ram[addr];
      end
      if (state == ST_RDATA && ocnt == '0 && sent &&
          operating_mode_register[MODE_HI:MODE_LO] == MODE_BYTE) begin
        // byte mode stops after one byte
        next_state   = ST_IGNORE;
        next_driving = 1'b0;
      end else begin
        next_driving = 1'b1;
        next_io_out  = out_bits(ob, width);
        next_out_sh  = ob << bpc(width);
        next_ocnt    = (ocnt == '0 ? 4'h8 : ocnt) - 4'(bpc(width));
        if (ocnt == '0 && state == ST_RDATA) begin
          next_sent   = 1'b1;
          next_addr_q = next_addr(addr,
            operating_mode_register[MODE_HI:MODE_LO]);
        end
      end
    end
    next_io_oe_n = (!cs_act || paused || !next_driving) ? 4'hf
                                                        : oe_mask(width);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state                   <= ST_IDLE;
      width                   <= w_single;
      operating_mode_register <= MODE_RESET;
      sh                      <= '0;
      cnt                     <= '0;
      addr                    <= '0;
      is_read                 <= 1'b0;
      out_sh                  <= '0;
      ocnt                    <= '0;
      driving                 <= 1'b0;
      sent                    <= 1'b0;
      io_out                  <= 4'h0;
      io_oe_n                 <= 4'hf;
      dual_width_mode         <= 1'b0;
      quad_width_mode         <= 1'b0;
    end else begin
      state                   <= next_state;
      width                   <= next_width;
      operating_mode_register <= next_mode;
      sh                      <= next_sh;
      cnt                     <= next_cnt;
      addr                    <= next_addr_q;
      is_read                 <= next_is_read;
      out_sh                  <= next_out_sh;
      ocnt                    <= next_ocnt;
      driving                 <= next_driving;
      sent                    <= next_sent;
      io_out                  <= next_io_out;
      io_oe_n                 <= next_io_oe_n;
      dual_width_mode         <= (next_width == w_dual);
      quad_width_mode         <= (next_width == w_quad);
    end
  end

  // ****************************************************************
  // write buffer and array
  // ****************************************************************
  sram_fifo #(
    .WIDTH (AW + 8),
    .DEPTH (DEPTH)
  ) u_wbuf (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (push),
    .in_ready  (in_ready),
    .in_data   ({addr, next_sh[7:0]}),
    .out_valid (wb_valid),
    .out_ready (wb_ready),
    .out_data  (wb_data)
  );

  // array port goes to the read stream first; writes wait
  assign wb_ready = (state != ST_RDATA);

  always_ff @(posedge clk) begin
    if (wb_valid && wb_ready) begin
      ram[wb_data[AW+7:8]] <= wb_data[7:0];
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  a_mode_reset: assert property (@(posedge clk)
    !rst_n |=> operating_mode_register == MODE_RESET)
    else $error("mode register not sequential after reset");

  a_mode_load: assert property (@(posedge clk) disable iff (!rst_n)
    (state == ST_MWR && byte_done) |=>
      operating_mode_register == $past(next_sh[7:0]) && state == ST_IGNORE)
    else $error("mode write not loaded");

  a_mode_read: assert property (@(posedge clk) disable iff (!rst_n)
    (state == ST_MRD && cs_act && !paused && fall && ocnt == '0) |=>
      io_out == out_bits(operating_mode_register, width) && driving)
    else $error("mode read drove wrong bits");

  a_enter_dual: assert property (@(posedge clk) disable iff (!rst_n)
    (state == ST_CMD && cs_act && !paused && rise && cnt + bpc(width) == 5'h08
     && next_sh[7:0] == enter_dual_cmd) |=> width == w_dual ##1 dual_width_mode)
    else $error("dual entry failed");

  a_enter_quad: assert property (@(posedge clk) disable iff (!rst_n)
    (state == ST_CMD && cs_act && !paused && rise && cnt + bpc(width) == 5'h08
     && next_sh[7:0] == enter_quad_cmd) |=> width == w_quad ##1 quad_width_mode)
    else $error("quad entry failed");

  a_exit_wide: assert property (@(posedge clk) disable iff (!rst_n)
    (state == ST_CMD && cs_act && !paused && rise && width != w_single &&
     cnt + bpc(width) == 5'h08 && next_sh[7:0] == exit_wide_cmd)
      |=> width == w_single)
    else $error("exit did not return to single");

  a_width_keep: assert property (@(posedge clk) disable iff (!rst_n)
    !cs_act |=> width == $past(width))
    else $error("width changed while deselected");

  a_dummy_len: assert property (@(posedge clk) disable iff (!rst_n)
    (state == ST_DUMMY && next_state == ST_RDATA) |->
      width == w_dual && cnt == 5'h06)
    else $error("dummy phase not four clocks");

  a_page_wrap: assert property (@(posedge clk) disable iff (!rst_n)
    (push && operating_mode_register[MODE_HI:MODE_LO] == MODE_PAGE) |=>
      addr[AW-1:PAGE_BITS] == $past(addr[AW-1:PAGE_BITS]) &&
      addr[PAGE_BITS-1:0] == $past(addr[PAGE_BITS-1:0]) + 1'b1)
    else $error("page address did not wrap in page");

  a_desel_float: assert property (@(posedge clk) disable iff (!rst_n)
    !cs_act |=> io_oe_n == 4'hf && state == ST_IDLE)
    else $error("lines driven while deselected");

  a_hold_float: assert property (@(posedge clk) disable iff (!rst_n)
    (cs_act && paused) |=> io_oe_n == 4'hf)
    else $error("lines driven while paused");
endmodule

// ---- logic/sram_pkg.sv ----
package sram_pkg;
  // instruction codes
  localparam logic [7:0] CMD_READ        = 8'h03;
  localparam logic [7:0] CMD_WRITE       = 8'h02;
  localparam logic [7:0] read_mode_cmd   = 8'h05;
  localparam logic [7:0] write_mode_cmd  = 8'h01;
  localparam logic [7:0] enter_dual_cmd  = 8'h3b;
  localparam logic [7:0] enter_quad_cmd  = 8'h38;
  localparam logic [7:0] exit_wide_cmd   = 8'hff;
  // operating mode register layout
  localparam logic [7:0] MODE_RESET      = 8'h40;
  localparam int         MODE_HI         = 7;
  localparam int         MODE_LO         = 6;
  localparam logic [1:0] MODE_BYTE       = 2'b00;
  localparam logic [1:0] MODE_PAGE       = 2'b10;
  localparam logic [1:0] MODE_SEQ        = 2'b01;
  // phase lengths in bits, array shape
  localparam logic [4:0] CMD_BITS        = 5'h08;
  localparam logic [4:0] ADDR_BITS       = 5'h18;
  localparam logic [4:0] DUMMY_BITS      = 5'h08;
  localparam int         PAGE_BITS       = 5;
  localparam int         ADDR_W          = 17;
  localparam int         FIFO_DEPTH      = 32;
  localparam int         DATA_W          = 8;
  // link width
  typedef enum logic [1:0] {w_single, w_dual, w_quad} width_e;
endpackage

// ---- tb/host_model.sv ----
`timescale 1ns/1ns

// ****************************************************************
// host serial controller model, drives select, clock and lines
// ****************************************************************
module host_model (
  input  wire logic       clk,
  input  wire logic [3:0] io_out,
  input  wire logic [3:0] io_oe_n,
  output logic            cs_n,
  output logic            sck,
  output logic [3:0]      io_in
);
  // a line the device releases reads back inverted, never stale
  logic [3:0] line;
  assign line = io_out ^ io_oe_n;

  // idle: deselected, clock parked low, hold released high
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    io_in = 4'h8;
  end

  // released lines flip so a stale level is never read back
  function automatic logic [3:0] idle_lines(input int w, input logic [3:0] v);
    return (w == 4) ? ~v : {1'b1, ~v[2:0]};
  endfunction

  // every change lands the same small delay after a clk edge
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  // select stays low for the whole command
  task automatic start();
    wait_clk(1);
    cs_n = 1'b0;
    wait_clk(4);
  endtask

  // raising select ends the command
  task automatic stop(input int w);
    wait_clk(4);
    cs_n = 1'b1;
    io_in = idle_lines(w, io_in);
    wait_clk(8);
  endtask

  // one byte out at the active width, msb first
  task automatic put_byte(input int w, input logic [7:0] b);
    logic [7:0] sh;
    logic [3:0] v;
    sh = b;
    for (int i = 0; i < 8; i += w) begin
      v = idle_lines(w, io_in);
      case (w)
        1: v[0] = sh[7];
        2: v[1:0] = sh[7:6];
        default: v = sh[7:4];
      endcase
      io_in = v;
      sh = sh << w;
      wait_clk(4);
      sck = 1'b1;
      wait_clk(4);
      sck = 1'b0;
    end
  endtask

  // one byte in, sampled late in the high phase
  task automatic get_byte(input int w, output logic [7:0] b);
    b = 8'h00;
    for (int i = 0; i < 8; i += w) begin
      io_in = idle_lines(w, io_in);
      wait_clk(4);
      sck = 1'b1;
      wait_clk(4);
      case (w)
        1: b = {b[6:0], line[1]};
        2: b = {b[5:0], line[1:0]};
        default: b = {b[3:0], line};
      endcase
      sck = 1'b0;
    end
  endtask

  // hold low pauses the link; a clock pulse meanwhile is ignored
  task automatic hold_on();
    wait_clk(4);
    io_in[3] = 1'b0;
    wait_clk(4);
    sck = 1'b1;
    wait_clk(4);
    sck = 1'b0;
    wait_clk(4);
  endtask

  // hold released with the clock low resumes the link
  task automatic hold_off();
    io_in[3] = 1'b1;
    wait_clk(4);
  endtask
endmodule

// ---- tb/tb_serial_sram_ctrl.sv ----
`timescale 1ns/1ns

// ****************************************************************
// self-checking bench for the serial sram command interpreter
// ****************************************************************
module tb_serial_sram_ctrl;
  import sram_pkg::*;
  logic        clk;
  logic        rst_n;
  logic        cs_n;
  logic        sck;
  logic [3:0]  io_in;
  logic [3:0]  io_out;
  logic [3:0]  io_oe_n;
  logic [7:0]  operating_mode_register;
  logic        dual_width_mode;
  logic        quad_width_mode;
  logic [7:0]  mem [256];
  logic [1:0]  mode_q;
  logic [15:0] lfsr;
  logic [7:0]  a;
  int          num_errors;
  int          check_count;

  serial_sram_ctrl #(.AW(8)) u_dut (
    .clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sck(sck), .io_in(io_in),
    .io_out(io_out), .io_oe_n(io_oe_n),
    .operating_mode_register(operating_mode_register),
    .dual_width_mode(dual_width_mode), .quad_width_mode(quad_width_mode)
  );

  host_model u_host (
    .clk(clk), .io_out(io_out), .io_oe_n(io_oe_n), .cs_n(cs_n), .sck(sck),
    .io_in(io_in)
  );

  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr[7:0];
  endfunction

  // expected pointer step: page wraps in 32 bytes, else whole array
  function automatic logic [7:0] next_addr(input logic [7:0] p,
                                           input logic [1:0] m);
    if (m == MODE_PAGE) return {p[7:5], p[4:0] + 5'h01};
    return p + 8'h01;
  endfunction

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      num_errors++;
    end
  endtask

  task automatic final_report();
    if (num_errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic end_xfer(input int w);
    u_host.stop(w);
    check({4'h0, io_oe_n}, 8'h0f);
  endtask

  // host restarted alone: exit at quad width, then at dual width
  task automatic recover();
    cmd_only(4, exit_wide_cmd);
    cmd_only(2, exit_wide_cmd);
  endtask

  // 24-bit address, top seven bits random, the next nine bits zero
  task automatic send_addr(input int w, input logic [7:0] p);
    logic [7:0] d;
    d = rnd();
    u_host.put_byte(w, {d[7:1], 1'b0});
    u_host.put_byte(w, 8'h00);
    u_host.put_byte(w, p);
  endtask

  task automatic cmd_only(input int w, input logic [7:0] c);
    u_host.start();
    u_host.put_byte(w, c);
    end_xfer(w);
  endtask

  task automatic check_width(input logic d, input logic q);
    check({6'h00, dual_width_mode, quad_width_mode}, {6'h00, d, q});
  endtask

  task automatic set_mode(input int w, input logic [1:0] m);
    u_host.start();
    u_host.put_byte(w, write_mode_cmd);
    u_host.put_byte(w, {m, 6'h00});
    end_xfer(w);
    mode_q = m;
    check(operating_mode_register, {m, 6'h00});
  endtask

  // the mode byte repeats while clocked
  task automatic read_mode(input int w);
    logic [7:0] got;
    u_host.start();
    u_host.put_byte(w, read_mode_cmd);
    repeat (2) begin
      u_host.get_byte(w, got);
      check(got, {mode_q, 6'h00});
    end
    end_xfer(w);
  endtask

  task automatic write_mem(input int w, input logic [7:0] p0, input int n);
    logic [7:0] d;
    logic [7:0] p;
    p = p0;
    u_host.start();
    u_host.put_byte(w, CMD_WRITE);
    send_addr(w, p0);
    for (int i = 0; i < n; i++) begin
      d = rnd();
      u_host.put_byte(w, d);
      if (i == 0 || mode_q != MODE_BYTE) mem[p] = d;
      p = next_addr(p, mode_q);
    end
    end_xfer(w);
  endtask

  task automatic read_check(input int w, input logic [7:0] p0, input int n);
    logic [7:0] got;
    logic [7:0] p;
    p = p0;
    u_host.start();
    u_host.put_byte(w, CMD_READ);
    send_addr(w, p0);
    if (w == 2) u_host.put_byte(w, rnd());
    for (int i = 0; i < n; i++) begin
      u_host.get_byte(w, got);
      check(got, mem[p]);
      p = next_addr(p, mode_q);
      if (i == 0 && w != 4) begin
        u_host.hold_on();
        check({4'h0, io_oe_n}, 8'h0f);
        u_host.hold_off();
      end
    end
    end_xfer(w);
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    rst_n = 1'b0;
    lfsr = 16'hce85;
    num_errors = 0;
    check_count = 0;
    repeat (20) @(posedge clk);
    #2;
    rst_n = 1'b1;
    repeat (3) @(posedge clk);
    #2;
    check(operating_mode_register, MODE_RESET);
    mode_q = MODE_SEQ;
    check_width(1'b0, 1'b0);
    read_mode(1);
    cmd_only(1, exit_wide_cmd);
    check_width(1'b0, 1'b0);
    write_mem(1, 8'hfd, 5);
    read_check(1, 8'hfd, 5);
    set_mode(1, MODE_PAGE);
    write_mem(1, 8'h3e, 4);
    read_check(1, 8'h3e, 4);
    set_mode(1, MODE_BYTE);
    write_mem(1, 8'h00, 2);
    read_check(1, 8'h00, 1);
    set_mode(1, MODE_SEQ);
    read_check(1, 8'hff, 3);
    cmd_only(1, enter_dual_cmd);
    check_width(1'b1, 1'b0);
    read_mode(2);
    a = rnd();
    write_mem(2, a, 6);
    read_check(2, a, 6);
    set_mode(2, MODE_PAGE);
    read_mode(2);
    cmd_only(2, exit_wide_cmd);
    check_width(1'b0, 1'b0);
    cmd_only(1, enter_quad_cmd);
    check_width(1'b0, 1'b1);
    a = rnd();
    write_mem(4, a, 5);
    read_check(4, a, 5);
    set_mode(4, MODE_SEQ);
    read_mode(4);
    cmd_only(4, exit_wide_cmd);
    check_width(1'b0, 1'b0);
    read_check(1, a, 5);
    cmd_only(1, enter_dual_cmd);
    recover();
    check_width(1'b0, 1'b0);
    cmd_only(1, enter_quad_cmd);
    recover();
    check_width(1'b0, 1'b0);
    recover();
    check_width(1'b0, 1'b0);
    cmd_only(1, 8'h5a);
    read_mode(1);
    final_report();
  end

  // watchdog against a hung run
  initial begin
    repeat (60000) @(posedge clk);
    $display("mismatch at %0t: watchdog expired", $time);
    num_errors++;
    final_report();
  end
endmodule
